// ==== design/lvoc_consts.vh ====
// Purpose: shared constants of the lvds output configuration block
// Assumes: included by its bare name from every design file
// Notes: offsets are byte addresses of the 8-bit configuration space
`ifndef LVOC_CONSTS_VH
`define LVOC_CONSTS_VH

// register offsets
`define LVOC_OFS_LEVEL 8'h19
`define LVOC_OFS_ROUTE 8'h1A

// reset values of whole registers
`define LVOC_RST_LEVEL 8'h05
`define LVOC_RST_ROUTE 8'h03

// field positions, level control register
`define LVOC_BIT_A_CM 6
`define LVOC_BIT_B_CM 4
`define LVOC_MSB_A_SW 3
`define LVOC_LSB_A_SW 2
`define LVOC_MSB_B_SW 1
`define LVOC_LSB_B_SW 0

// field positions, routing and termination register
`define LVOC_BIT_SWAP 6
`define LVOC_BIT_A_REV 5
`define LVOC_BIT_B_REV 4
`define LVOC_BIT_A_TERM 1
`define LVOC_BIT_B_TERM 0

// field reset values
`define LVOC_RST_CM 1'h0
`define LVOC_RST_SW 2'h1
`define LVOC_RST_SWAP 1'h0
`define LVOC_RST_REV 1'h0
`define LVOC_RST_TERM 1'h1

// stream mode code meaning two independent streams
`define LVOC_MODE_TWO_STREAM 2'h2

// lane indices within one channel: data 0..3, then clock
`define LVOC_LANES 5
`define LVOC_LANE_Y0 0
`define LVOC_LANE_Y1 1
`define LVOC_LANE_Y2 2
`define LVOC_LANE_Y3 3
`define LVOC_LANE_CLK 4

// read value of an unmapped address
`define LVOC_RD_NONE 8'h00

`endif

// ==== design/lvoc_lane_map.v ====
// Purpose: optional pin-order reversal of one lvds output channel
// Assumes: lane vector holds data lanes 0..3 then the clock lane
// Notes: one bit stands for a differential pair, both legs follow it
`include "lvoc_consts.vh"

module lvoc_lane_map (
  input wire reverse_in,
  input wire [`LVOC_LANES-1:0] lanes_in,
  output reg [`LVOC_LANES-1:0] lanes_out
);

  // swap 0<->3 and 1<->clk when reversed, lane 2 stays
  always @* begin
    lanes_out = lanes_in;
    if (reverse_in) begin
      lanes_out[`LVOC_LANE_Y0] = lanes_in[`LVOC_LANE_Y3];
      lanes_out[`LVOC_LANE_Y3] = lanes_in[`LVOC_LANE_Y0];
      lanes_out[`LVOC_LANE_Y1] = lanes_in[`LVOC_LANE_CLK];
      lanes_out[`LVOC_LANE_CLK] = lanes_in[`LVOC_LANE_Y1];
    end
  end

endmodule

// ==== design/lvoc_regs.v ====
// Purpose: lvds output level, routing and termination configuration
// Assumes: register port and pixel lanes run on core_clk_in
// Notes: stream mode comes from a neighbouring register, same clock
`include "lvoc_consts.vh"

// Summary of operation
// - bit 6 picks channel A common level: 0 high (reset), 1 low.
// - bit 4 picks channel B common level: 0 high (reset), 1 low.
// - bits 3:2 choose channel A differential swing, reset 01.
// - bits 1:0 choose channel B differential swing, reset 01.
// - swap clear sends odd pixels to A; set sends odd to B.
// - in two-stream mode swap sends stream A to B, B to A.
// - channel A reverse clear keeps lanes on normal pins.
// - channel A reverse set swaps lane 0/3 and 1/clock.
// - channel B reverse bit applies the same swap to B.
// - bits 1 and 0 select A and B termination, reset high-ohm.
module lvoc_regs (
  input wire core_clk_in,
  input wire rst_n_in,
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [7:0] reg_rdata_out,
  input wire [1:0] stream_mode_in,
  input wire [`LVOC_LANES-1:0] odd_lanes_in,
  input wire [`LVOC_LANES-1:0] even_lanes_in,
  output reg [`LVOC_LANES-1:0] chan_a_lanes_out,
  output reg [`LVOC_LANES-1:0] chan_b_lanes_out,
  output reg chan_a_common_level_sel_out,
  output reg chan_b_common_level_sel_out,
  output reg [1:0] chan_a_diff_swing_out,
  output reg [1:0] chan_b_diff_swing_out,
  output reg chan_a_termination_sel_out,
  output reg chan_b_termination_sel_out,
  output reg two_stream_swapped_out
);

  // field storage
  reg chan_a_common_level_sel_ff;
  reg chan_b_common_level_sel_ff;
  reg [1:0] chan_a_diff_swing_ff;
  reg [1:0] chan_b_diff_swing_ff;
  reg pixel_swap_ff;
  reg chan_a_lane_reverse_ff;
  reg chan_b_lane_reverse_ff;
  reg chan_a_termination_sel_ff;
  reg chan_b_termination_sel_ff;

  // next values
  reg nxt_chan_a_common_level_sel;
  reg nxt_chan_b_common_level_sel;
  reg [1:0] nxt_chan_a_diff_swing;
  reg [1:0] nxt_chan_b_diff_swing;
  reg nxt_pixel_swap;
  reg nxt_chan_a_lane_reverse;
  reg nxt_chan_b_lane_reverse;
  reg nxt_chan_a_termination_sel;
  reg nxt_chan_b_termination_sel;
  reg [7:0] nxt_rdata;

  // decode and assembled read images
  wire wr_level;
  wire wr_route;
  wire [7:0] level_image;
  wire [7:0] route_image;

  // routing and lane mapping
  reg [`LVOC_LANES-1:0] routed_a;
  reg [`LVOC_LANES-1:0] routed_b;
  wire [2*`LVOC_LANES-1:0] routed_both;
  wire [2*`LVOC_LANES-1:0] mapped_both;
  wire [1:0] reverse_both;
  wire two_stream;

  // address decode of write strobes
  assign wr_level = reg_wr_in && (reg_addr_in == `LVOC_OFS_LEVEL);
  assign wr_route = reg_wr_in && (reg_addr_in == `LVOC_OFS_ROUTE);

  // read images, reserved positions forced to zero
  assign level_image = {1'b0,
                        chan_a_common_level_sel_ff,
                        1'b0,
                        chan_b_common_level_sel_ff,
                        chan_a_diff_swing_ff,
                        chan_b_diff_swing_ff};
  assign route_image = {1'b0,
                        pixel_swap_ff,
                        chan_a_lane_reverse_ff,
                        chan_b_lane_reverse_ff,
                        2'h0,
                        chan_a_termination_sel_ff,
                        chan_b_termination_sel_ff};

  // level control register writes, reserved bits dropped
  always @* begin
    nxt_chan_a_common_level_sel = chan_a_common_level_sel_ff;
    nxt_chan_b_common_level_sel = chan_b_common_level_sel_ff;
    nxt_chan_a_diff_swing = chan_a_diff_swing_ff;
    nxt_chan_b_diff_swing = chan_b_diff_swing_ff;
    if (wr_level) begin
      // low level also needs the fine trim set by software
      nxt_chan_a_common_level_sel =
        reg_wdata_in[`LVOC_BIT_A_CM];
      nxt_chan_b_common_level_sel =
        reg_wdata_in[`LVOC_BIT_B_CM];
      nxt_chan_a_diff_swing =
        reg_wdata_in[`LVOC_MSB_A_SW:`LVOC_LSB_A_SW];
      nxt_chan_b_diff_swing =
        reg_wdata_in[`LVOC_MSB_B_SW:`LVOC_LSB_B_SW];
    end
  end

  // routing and termination register writes
  always @* begin
    nxt_pixel_swap = pixel_swap_ff;
    nxt_chan_a_lane_reverse = chan_a_lane_reverse_ff;
    nxt_chan_b_lane_reverse = chan_b_lane_reverse_ff;
    nxt_chan_a_termination_sel = chan_a_termination_sel_ff;
    nxt_chan_b_termination_sel = chan_b_termination_sel_ff;
    if (wr_route) begin
      nxt_pixel_swap = reg_wdata_in[`LVOC_BIT_SWAP];
      nxt_chan_a_lane_reverse =
        reg_wdata_in[`LVOC_BIT_A_REV];
      nxt_chan_b_lane_reverse = reg_wdata_in[`LVOC_BIT_B_REV];
      nxt_chan_a_termination_sel =
        reg_wdata_in[`LVOC_BIT_A_TERM];
      nxt_chan_b_termination_sel =
        reg_wdata_in[`LVOC_BIT_B_TERM];
    end
  end

  // read mux, data stand one cycle after the read strobe
  always @* begin
    nxt_rdata = `LVOC_RD_NONE;
    if (reg_rd_in) begin
      case (reg_addr_in)
        `LVOC_OFS_LEVEL: begin
          nxt_rdata = level_image;
        end
        `LVOC_OFS_ROUTE: begin
          nxt_rdata = route_image;
        end
        default: begin
          nxt_rdata = `LVOC_RD_NONE;
        end
      endcase
    end
  end

  // configuration flip-flops
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      chan_a_common_level_sel_ff <= `LVOC_RST_CM;
      chan_b_common_level_sel_ff <= `LVOC_RST_CM;
      chan_a_diff_swing_ff <= `LVOC_RST_SW;
      chan_b_diff_swing_ff <= `LVOC_RST_SW;
      pixel_swap_ff <= `LVOC_RST_SWAP;
      chan_a_lane_reverse_ff <= `LVOC_RST_REV;
      chan_b_lane_reverse_ff <= `LVOC_RST_REV;
      chan_a_termination_sel_ff <= `LVOC_RST_TERM;
      chan_b_termination_sel_ff <= `LVOC_RST_TERM;
    end else begin
      chan_a_common_level_sel_ff <= nxt_chan_a_common_level_sel;
      chan_b_common_level_sel_ff <= nxt_chan_b_common_level_sel;
      chan_a_diff_swing_ff <= nxt_chan_a_diff_swing;
      chan_b_diff_swing_ff <= nxt_chan_b_diff_swing;
      pixel_swap_ff <= nxt_pixel_swap;
      chan_a_lane_reverse_ff <= nxt_chan_a_lane_reverse;
      chan_b_lane_reverse_ff <= nxt_chan_b_lane_reverse;
      chan_a_termination_sel_ff <= nxt_chan_a_termination_sel;
      chan_b_termination_sel_ff <= nxt_chan_b_termination_sel;
    end
  end

  // stream mode decode
  assign two_stream = (stream_mode_in == `LVOC_MODE_TWO_STREAM);

  // odd/even or stream A/B routing onto the two channels
  always @* begin
    routed_a = odd_lanes_in;
    routed_b = even_lanes_in;
    if (pixel_swap_ff) begin
      // in two-stream mode odd input carries stream A
      routed_a = even_lanes_in;
      routed_b = odd_lanes_in;
    end
  end

  assign routed_both = {routed_b, routed_a};
  assign reverse_both = {chan_b_lane_reverse_ff, chan_a_lane_reverse_ff};

  // per-channel pin order mapping, index 0 is channel A
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
      lvoc_lane_map u_map (
        .reverse_in(reverse_both[ch]),
        .lanes_in(routed_both[ch*`LVOC_LANES +: `LVOC_LANES]),
        .lanes_out(mapped_both[ch*`LVOC_LANES +: `LVOC_LANES])
      );
    end
  endgenerate

  // registered outputs
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= `LVOC_RD_NONE;
      chan_a_lanes_out <= {`LVOC_LANES{1'b0}};
      chan_b_lanes_out <= {`LVOC_LANES{1'b0}};
      chan_a_common_level_sel_out <= `LVOC_RST_CM;
      chan_b_common_level_sel_out <= `LVOC_RST_CM;
      chan_a_diff_swing_out <= `LVOC_RST_SW;
      chan_b_diff_swing_out <= `LVOC_RST_SW;
      chan_a_termination_sel_out <= `LVOC_RST_TERM;
      chan_b_termination_sel_out <= `LVOC_RST_TERM;
      two_stream_swapped_out <= 1'b0;
    end else begin
      reg_rdata_out <= nxt_rdata;
      chan_a_lanes_out <= mapped_both[`LVOC_LANES-1:0];
      chan_b_lanes_out <= mapped_both[2*`LVOC_LANES-1:`LVOC_LANES];
      chan_a_common_level_sel_out <= nxt_chan_a_common_level_sel;
      chan_b_common_level_sel_out <= nxt_chan_b_common_level_sel;
      chan_a_diff_swing_out <= nxt_chan_a_diff_swing;
      chan_b_diff_swing_out <= nxt_chan_b_diff_swing;
      chan_a_termination_sel_out <= nxt_chan_a_termination_sel;
      chan_b_termination_sel_out <= nxt_chan_b_termination_sel;
      two_stream_swapped_out <= two_stream && pixel_swap_ff;
    end
  end

endmodule

// ==== test/lvoc_regs_asserts.sv ====
// Purpose: port checks of the lvds output configuration block
// Assumes: bound to lvoc_regs, reset synchronous and active low
// Notes: swap and reverse bits are not ports, so lanes get partial checks
`include "lvoc_consts.vh"
module lvoc_chk (
  input wire core_clk_in,
  input wire rst_n_in,
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [7:0] reg_rdata_out,
  input wire [1:0] stream_mode_in,
  input wire [`LVOC_LANES-1:0] odd_lanes_in,
  input wire [`LVOC_LANES-1:0] even_lanes_in,
  input wire [`LVOC_LANES-1:0] chan_a_lanes_out,
  input wire [`LVOC_LANES-1:0] chan_b_lanes_out,
  input wire chan_a_common_level_sel_out,
  input wire chan_b_common_level_sel_out,
  input wire [1:0] chan_a_diff_swing_out,
  input wire [1:0] chan_b_diff_swing_out,
  input wire chan_a_termination_sel_out,
  input wire chan_b_termination_sel_out,
  input wire two_stream_swapped_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // level register image rebuilt from the config outputs
  wire [7:0] lvl = {1'b0, chan_a_common_level_sel_out, 1'b0,
    chan_b_common_level_sel_out, chan_a_diff_swing_out, chan_b_diff_swing_out};
  wire [1:0] trm = {chan_a_termination_sel_out, chan_b_termination_sel_out};
  wire lv = reg_addr_in == `LVOC_OFS_LEVEL;
  wire rt = reg_addr_in == `LVOC_OFS_ROUTE;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  a_rd_idle: assert property (
    !reg_rd_in |=> reg_rdata_out == `LVOC_RD_NONE) else $error("rd idle");
  a_rd_level: assert property (
    reg_rd_in && lv |=> reg_rdata_out == $past(lvl)) else $error("rd lvl");
  a_rd_route: assert property (
    reg_rd_in && rt |=> (reg_rdata_out & 8'h8F) == {6'h00, $past(trm)})
    else $error("rd route");
  a_rd_unmap: assert property (
    reg_rd_in && !lv && !rt |=> reg_rdata_out == 8'h00) else $error("unmap");
  a_wr_level: assert property (
    reg_wr_in && lv |=> lvl == ($past(reg_wdata_in) & 8'h5F))
    else $error("wr lvl");
  a_wr_term: assert property (
    reg_wr_in && rt |=> trm == $past(reg_wdata_in[1:0])) else $error("term");
  a_cfg_hold: assert property (
    !(reg_wr_in && (lv || rt)) |=> $stable(lvl) && $stable(trm))
    else $error("cfg moved");
  a_lane_mid: assert property (
    1'b1 |=> {chan_a_lanes_out[2], chan_b_lanes_out[2]} ==
    $past({odd_lanes_in[2], even_lanes_in[2]}) ||
    {chan_a_lanes_out[2], chan_b_lanes_out[2]} ==
    $past({even_lanes_in[2], odd_lanes_in[2]})) else $error("lane 2");
  a_two_off: assert property (
    stream_mode_in != `LVOC_MODE_TWO_STREAM |=> !two_stream_swapped_out)
    else $error("two stream");
  c_rd_lvl: cover property (reg_rd_in && lv);
  c_wr_rt: cover property (reg_wr_in && rt);
  c_two: cover property (two_stream_swapped_out);
endmodule
bind lvoc_regs lvoc_chk u_chk (.core_clk_in, .rst_n_in, .reg_addr_in,
  .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .stream_mode_in,
  .odd_lanes_in, .even_lanes_in, .chan_a_lanes_out, .chan_b_lanes_out,
  .chan_a_common_level_sel_out, .chan_b_common_level_sel_out,
  .chan_a_diff_swing_out, .chan_b_diff_swing_out, .chan_a_termination_sel_out,
  .chan_b_termination_sel_out, .two_stream_swapped_out);

// ==== test/lvoc_panel.sv ====
// Purpose: panel model latching both lvds channels
// Assumes: one lane bit per differential pair
// Notes: keeps the last word seen on each channel
module lvoc_panel (
  input wire clk_in,
  input wire [4:0] a_in,
  input wire [4:0] b_in,
  output logic [4:0] a_seen_out,
  output logic [4:0] b_seen_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // capture both channels every clock
  always @(posedge clk_in) begin
    a_seen_out <= a_in;
    b_seen_out <= b_in;
  end
endmodule

// ==== test/tb.sv ====
// Purpose: self-checking bench of the lvds output configuration block
// Assumes: 50 MHz clock, synchronous active-low reset
// Notes: fine trim lives outside the block, written as software would
`include "lvoc_consts.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_in = 0, rst_n_in = 0, reg_wr_in = 0, reg_rd_in = 0;
  logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00;
  logic [1:0] stream_mode_in = 2'h0;
  logic [4:0] odd_lanes_in = 5'h00, even_lanes_in = 5'h00;
  wire [7:0] reg_rdata_out;
  wire [4:0] chan_a_lanes_out, chan_b_lanes_out, a_seen, b_seen;
  wire chan_a_common_level_sel_out, chan_b_common_level_sel_out;
  wire [1:0] chan_a_diff_swing_out, chan_b_diff_swing_out;
  wire chan_a_termination_sel_out, chan_b_termination_sel_out;
  wire two_stream_swapped_out;
  wire [7:0] lvl = {1'b0, chan_a_common_level_sel_out, 1'b0,
    chan_b_common_level_sel_out, chan_a_diff_swing_out, chan_b_diff_swing_out};
  wire [7:0] trm = {6'h00, chan_a_termination_sel_out,
    chan_b_termination_sel_out};
  int failures = 0, total_checks = 0;
  lvoc_regs dut (.core_clk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in,
    .reg_wr_in, .reg_rd_in, .reg_rdata_out, .stream_mode_in, .odd_lanes_in,
    .even_lanes_in, .chan_a_lanes_out, .chan_b_lanes_out,
    .chan_a_common_level_sel_out, .chan_b_common_level_sel_out,
    .chan_a_diff_swing_out, .chan_b_diff_swing_out,
    .chan_a_termination_sel_out, .chan_b_termination_sel_out,
    .two_stream_swapped_out);
  lvoc_panel panel (.clk_in(core_clk_in), .a_in(chan_a_lanes_out),
    .b_in(chan_b_lanes_out), .a_seen_out(a_seen), .b_seen_out(b_seen));
  // clock and watchdog
  initial forever #10 core_clk_in = ~core_clk_in;
  initial begin
    repeat (20000) @(posedge core_clk_in);
    failures++;
    end_of_test();
  end
  task automatic end_of_test();
    if (failures == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // register port cycles
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
    #1 chk(reg_rdata_out, exp);
  endtask
  function automatic logic [4:0] rv(input logic r, input logic [4:0] x);
    return r ? {x[1], x[0], x[2], x[4], x[3]} : x;
  endfunction
  task automatic t_reset();
    rst_n_in <= 1'b0;
    repeat (4) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    @(posedge core_clk_in);
    #1 chk(lvl, `LVOC_RST_LEVEL);
    chk(trm, 8'h03);
    rd(`LVOC_OFS_LEVEL, `LVOC_RST_LEVEL);
    rd(`LVOC_OFS_ROUTE, `LVOC_RST_ROUTE);
    rd(8'h18, 8'h00);
  endtask
  task automatic t_level();
    logic [7:0] v [4] = '{8'hF0, 8'h0B, 8'hA6, 8'hFF};
    wr(8'h1B, 8'h11);
    for (int i = 0; i < 4; i++) begin
      wr(`LVOC_OFS_LEVEL, v[i]);
      #1 chk(lvl, v[i] & 8'h5F);
      rd(`LVOC_OFS_LEVEL, v[i] & 8'h5F);
    end
    rd(8'h1B, 8'h00);
  endtask
  task automatic t_route();
    wr(`LVOC_OFS_ROUTE, 8'h8C);
    #1 chk(trm, 8'h00);
    rd(`LVOC_OFS_ROUTE, 8'h00);
  endtask
  // lane patterns differ on 0/3, 1/clock and lane 2, so every swap shows
  task automatic t_lanes();
    logic [7:0] d;
    logic [4:0] ea;
    logic [4:0] eb;
    logic ex;
    for (int k = 0; k < 8; k++) begin
      @(posedge core_clk_in);
      d = {1'b0, k[2:0], 4'h3};
      ea = rv(k[1], k[2] ? 5'h1C : 5'h03);
      eb = rv(k[0], k[2] ? 5'h03 : 5'h1C);
      ex = k[0] & ~k[1] & k[2];
      odd_lanes_in <= 5'h03;
      even_lanes_in <= 5'h1C;
      stream_mode_in <= {k[0], k[1]};
      wr(`LVOC_OFS_ROUTE, d);
      rd(`LVOC_OFS_ROUTE, d);
      repeat (2) @(posedge core_clk_in);
      #1 chk({3'h0, a_seen}, {3'h0, ea});
      chk({3'h0, b_seen}, {3'h0, eb});
      chk({7'h00, two_stream_swapped_out}, {7'h00, ex});
    end
  endtask
  // main sequence, ends with a mid-run reset
  initial begin
    t_reset();
    t_level();
    t_route();
    t_lanes();
    @(posedge core_clk_in);
    t_reset();
    end_of_test();
  end
endmodule
